// ==== core/saf_pkg.sv ====
// Shared constants for the system alert message framer
package saf_pkg;

	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam longint unsigned CLK_HZ       = 64'd100_000_000; // Register clock rate
	localparam int              CLK_NS       = 10;              // Register clock period
	localparam longint unsigned HB_TIME_S    = 64'd31;          // Heartbeat, inside 30 to 32 s
	localparam longint unsigned HB_CYC_L     = HB_TIME_S * CLK_HZ;
	localparam logic [31:0]     HB_CYCLES    = HB_CYC_L[31:0];  // 3.1e9 fits 32 bits
	localparam int              LINK_HALF_NS = 60;              // Half period of link clock
	localparam int              LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL   = 8'h00; // Request and sleep trigger
	localparam logic [7:0] OFF_MSG1   = 8'h04; // User message one
	localparam logic [7:0] OFF_MSG2   = 8'h08; // User message two
	localparam logic [7:0] OFF_WD     = 8'h0c; // Watchdog state byte
	localparam logic [7:0] OFF_STATUS = 8'h10; // Counter, power state, link

	// Control fields
	localparam int CTRL_REQ   = 0; // Transmit request, write one
	localparam int CTRL_SLEEP = 1; // Sleep entry trigger, write one
	localparam int CTRL_TYPE  = 2; // Sleep type field, 3 bits
	localparam int TYPE_W     = 3;
	localparam logic [2:0] TYPE_S1 = 3'h1; // S1 .. S4 give sleeping
	localparam logic [2:0] TYPE_S4 = 3'h4;
	localparam logic [2:0] TYPE_S5 = 3'h5; // Soft-off

	// Status fields
	localparam int ST_SEQ  = 0; // Message counter, 4 bits
	localparam int ST_PWR  = 4; // Power state code, 2 bits
	localparam int ST_BUSY = 6; // Message in flight
	localparam int ST_NACK = 7; // Sticky missing acknowledge, write one clears

	// Reset values
	localparam logic [7:0] MSG_RST = 8'h00;
	localparam logic [3:0] SEQ_RST = 4'h0;

	// ----------------------------------------------------------------
	// Power state codes and message layout
	// ----------------------------------------------------------------
	localparam logic [1:0] PWR_WORK    = 2'h0;
	localparam logic [1:0] PWR_SLEEP   = 2'h1;
	localparam logic [1:0] PWR_SOFTOFF = 2'h2;
	localparam logic [1:0] PWR_PREBOOT = 2'h3;
	localparam int FRAME_BITS = 33; // Three status, counter, power, three bytes

	// Pin synchroniser slots and their idle levels
	localparam int SY_EVT  = 0; // Event input pin
	localparam int SY_CPU  = 1; // Processor reset, active low
	localparam int SY_OVR  = 2; // Power button override
	localparam int SY_WAKE = 3; // Wake event
	localparam int SY_CLK  = 4; // Link clock readback
	localparam int SY_DAT  = 5; // Link data readback
	localparam int SY_N    = 6;
	localparam logic [5:0] SY_RST = 6'h31;

endpackage : saf_pkg

// ==== core/saf_shifter.sv ====
// Open-drain two-wire shifter for one alert message
`timescale 1ns/1ns
module saf_shifter #(
	parameter int HALF = saf_pkg::LINK_HALF_CYC, // Cycles per clock half
	parameter int NB   = saf_pkg::FRAME_BITS     // Message bits
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          start,    // Take frame, idle only
	input  wire logic [NB-1:0] frame,
	input  wire logic          scl_in,   // Synchronised link clock
	input  wire logic          sda_in,   // Synchronised link data
	output logic               busy,
	output logic               done,     // One cycle at stop
	output logic               ack_ok,   // Last acknowledge seen
	output logic               scl_oe,   // Pull clock low
	output logic               sda_oe    // Pull data low
);

	typedef enum logic [1:0] {SH_IDLE, SH_START, SH_LOW, SH_HIGH} saf_sh_e;

	saf_sh_e         state;  // Shift phase
	logic [NB-1:0]   shift;  // Message, MSB at the top
	logic [5:0]      idx;    // Bit slot, NB is the acknowledge
	logic [7:0]      cnt;    // Half period counter
	logic            half_end;
	logic            next_sda;

	// ----------------------------------------------------------------
	// Slot decode
	// ----------------------------------------------------------------
	assign half_end = (cnt == 8'(HALF - 1));
	// Data bits MSB first, released for acknowledge, low before stop
	assign next_sda = (idx < 6'(NB)) ? ~shift[NB-1] : (idx != 6'(NB)); // R7 R19
	assign busy     = (state != SH_IDLE);

	// ----------------------------------------------------------------
	// Shift sequencer
	// ----------------------------------------------------------------
	// Data only moves two cycles into the low half, well clear of edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state  <= SH_IDLE;
			shift  <= '0;
			idx    <= 6'h00;
			cnt    <= 8'h00;
			done   <= 1'b0;
			ack_ok <= 1'b0;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				SH_IDLE: begin
					if (start) begin // Start: data falls with clock high
						shift  <= frame;
						sda_oe <= 1'b1;
						cnt    <= 8'h00;
						state  <= SH_START;
					end
				end
				SH_START: begin
					cnt <= cnt + 8'h01;
					if (half_end) begin
						scl_oe <= 1'b1;
						idx    <= 6'h00;
						cnt    <= 8'h00;
						state  <= SH_LOW;
					end
				end
				SH_LOW: begin
					cnt <= cnt + 8'h01;
					if (cnt == 8'h01) begin
						sda_oe <= next_sda;
					end
					if (half_end) begin
						scl_oe <= 1'b0;
						cnt    <= 8'h00;
						state  <= SH_HIGH;
					end
				end
				SH_HIGH: begin
					// Stretched clock holds the count
					if (scl_in) begin
						cnt <= cnt + 8'h01;
					end
					if (scl_in && half_end) begin
						cnt <= 8'h00;
						if (idx == 6'(NB)) begin
							ack_ok <= ~sda_in; // R19
						end
						if (idx == 6'(NB + 1)) begin // Stop: data rises
							sda_oe <= 1'b0;
							done   <= 1'b1;
							state  <= SH_IDLE;
						end else begin
							scl_oe <= 1'b1;
							idx    <= idx + 6'h01;
							shift  <= {shift[NB-2:0], 1'b0};
							state  <= SH_LOW;
						end
					end
				end
				default: state <= SH_IDLE;
			endcase
		end
	end

endmodule : saf_shifter

// ==== core/saf_framer.sv ====
// System alert message framer: registers, power states, events, link
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns

// Functional notes
// R1 - Health timer expiry sets its status bit
// R2 - Software request write sets software status bit
// R3 - Status bit reports event pin inverted
// R4 - Either event pin edge starts a message
// R5 - Four-bit counter from zero, one per message
// R6 - Counter wraps from all ones to zero
// R7 - Every multi-bit field goes MSB first
// R8 - Power code: 00 work, 01 sleep, 10 off, 11 preboot
// R9 - User bytes copied from their registers
// R10 - Watchdog byte copied from its register
// R11 - Pre-boot entered when deep sleep control released
// R12 - Pre-boot left on processor reset release or override
// R13 - Working left on sleep trigger or override
// R14 - Sleep trigger with S1-S4 enters sleeping
// R15 - Sleeping left on wake or override
// R16 - S5 or override enters soft-off; wake leaves
// R17 - Heartbeat message every 30-32 s while sleeping
// R18 - Events sent at once, heartbeat then resumes
// R19 - Controller acknowledges, device checks it
// R20 - All fields captured when message starts
module saf_framer #(
	parameter logic [31:0] HB_CYCLES = saf_pkg::HB_CYCLES, // Heartbeat period
	parameter int          HALF      = saf_pkg::LINK_HALF_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        health_timer_expired,  // One-cycle pulse, same clock
	input  wire logic        event_input_pin,
	input  wire logic        processor_reset_n,
	input  wire logic        power_button_override,
	input  wire logic        wake_event,
	output logic             deep_sleep_control_n,
	input  wire logic        alert_link_clock_i,
	output logic             alert_link_clock_o,
	output logic             alert_link_clock_oe,
	input  wire logic        alert_link_data_i,
	output logic             alert_link_data_o,
	output logic             alert_link_data_oe
);

	typedef enum logic [1:0] {PS_PREBOOT, PS_WORK, PS_SLEEP, PS_SOFTOFF} saf_pwr_e;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [saf_pkg::SY_N-1:0] sync1;      // First stage, read by sync2 only
	logic [saf_pkg::SY_N-1:0] sync2;      // Settled pin levels
	logic                     evt_q;      // Previous settled event pin
	logic                     cpu_q;      // Previous settled processor reset
	saf_pwr_e                 pstate;     // System power state
	logic [7:0]               user_message_one;
	logic [7:0]               user_message_two;
	logic [7:0]               watchdog_state_byte;
	logic [3:0]               message_counter;
	logic                     ev_health;  // Pending health timer event
	logic                     ev_sw;      // Pending software request
	logic                     ev_other;   // Pin edge or pre-boot entry
	logic                     nack;       // Sticky missing acknowledge
	logic [31:0]              hb_cnt;     // Heartbeat timer
	logic [saf_pkg::FRAME_BITS-1:0] frame; // Captured message
	logic                     tx_start;
	logic                     tx_busy;
	logic                     tx_done;
	logic                     tx_ack;
	logic                     scl_oe;
	logic                     sda_oe;

	// Decode wires
	logic        wr;
	logic        rd_setup;
	logic        mapped;
	logic        wr_ctrl;
	logic        transmit_request_bit;
	logic        sleep_entry_trigger;
	logic [2:0]  sleep_type_field;
	logic        evt_edge;
	logic        cpu_rise;
	logic        ovr;
	logic        wake;
	logic        hb_due;
	logic        go_sleep;
	logic        go_off;
	logic        to_preboot;
	logic [1:0]  pwr_code;
	logic [31:0] rd_mux;
	logic [31:0] status_word;

	// Register select on a byte address
	function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
		sel = (a == off);
	endfunction : sel

	// Pin selection for the synchroniser slots
	function automatic logic sync_in(input int i);
		case (i)
			saf_pkg::SY_EVT:  sync_in = event_input_pin;
			saf_pkg::SY_CPU:  sync_in = processor_reset_n;
			saf_pkg::SY_OVR:  sync_in = power_button_override;
			saf_pkg::SY_WAKE: sync_in = wake_event;
			saf_pkg::SY_CLK:  sync_in = alert_link_clock_i;
			default:          sync_in = alert_link_data_i;
		endcase
	endfunction : sync_in

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// Every outside level passes two flops before logic sees it
	genvar gi;
	generate
		for (gi = 0; gi < saf_pkg::SY_N; gi++) begin : g_sync
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync1[gi] <= saf_pkg::SY_RST[gi];
					sync2[gi] <= saf_pkg::SY_RST[gi];
				end else begin
					sync1[gi] <= sync_in(gi);
					sync2[gi] <= sync1[gi];
				end
			end
		end
	endgenerate

	// Previous levels for edge finding, taken from the second stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_q <= saf_pkg::SY_RST[saf_pkg::SY_EVT];
			cpu_q <= saf_pkg::SY_RST[saf_pkg::SY_CPU];
		end else begin
			evt_q <= sync2[saf_pkg::SY_EVT];
			cpu_q <= sync2[saf_pkg::SY_CPU];
		end
	end

	assign evt_edge = sync2[saf_pkg::SY_EVT] ^ evt_q;           // R4
	assign cpu_rise = sync2[saf_pkg::SY_CPU] & ~cpu_q;
	assign ovr      = sync2[saf_pkg::SY_OVR];
	assign wake     = sync2[saf_pkg::SY_WAKE];

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	// Zero wait states: read data is loaded during the setup cycle
	assign pready   = 1'b1;
	assign wr       = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign mapped   = sel(paddr, saf_pkg::OFF_CTRL) | sel(paddr, saf_pkg::OFF_MSG1)
	                | sel(paddr, saf_pkg::OFF_MSG2) | sel(paddr, saf_pkg::OFF_WD)
	                | sel(paddr, saf_pkg::OFF_STATUS);
	assign pslverr  = psel & penable & ~mapped;
	assign wr_ctrl  = wr & sel(paddr, saf_pkg::OFF_CTRL);
	assign transmit_request_bit = wr_ctrl & pwdata[saf_pkg::CTRL_REQ];
	assign sleep_entry_trigger  = wr_ctrl & pwdata[saf_pkg::CTRL_SLEEP];
	assign sleep_type_field     = pwdata[saf_pkg::CTRL_TYPE +: saf_pkg::TYPE_W];

	assign status_word = {24'h000000, nack, tx_busy, pwr_code, message_counter};
	assign rd_mux = sel(paddr, saf_pkg::OFF_MSG1)   ? {24'h000000, user_message_one} :
	                sel(paddr, saf_pkg::OFF_MSG2)   ? {24'h000000, user_message_two} :
	                sel(paddr, saf_pkg::OFF_WD)     ? {24'h000000, watchdog_state_byte} :
	                sel(paddr, saf_pkg::OFF_STATUS) ? status_word : 32'h00000000;

	// Read data register; control reads back as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (rd_setup) begin
			prdata <= rd_mux;
		end
	end

	// Message bytes, read live into each capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			user_message_one    <= saf_pkg::MSG_RST;
			user_message_two    <= saf_pkg::MSG_RST;
			watchdog_state_byte <= saf_pkg::MSG_RST;
		end else if (wr) begin
			if (sel(paddr, saf_pkg::OFF_MSG1)) begin
				user_message_one <= pwdata[7:0];
			end
			if (sel(paddr, saf_pkg::OFF_MSG2)) begin
				user_message_two <= pwdata[7:0];
			end
			if (sel(paddr, saf_pkg::OFF_WD)) begin
				watchdog_state_byte <= pwdata[7:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Power state sequencer
	// ----------------------------------------------------------------
	assign go_sleep = sleep_entry_trigger && (sleep_type_field >= saf_pkg::TYPE_S1)
	                  && (sleep_type_field <= saf_pkg::TYPE_S4);
	assign go_off   = sleep_entry_trigger && (sleep_type_field == saf_pkg::TYPE_S5);
	// Wake releases deep sleep control, which is the pre-boot entry
	assign to_preboot = ((pstate == PS_SLEEP) || (pstate == PS_SOFTOFF)) && wake && !ovr;
	assign deep_sleep_control_n = (pstate != PS_SLEEP) && (pstate != PS_SOFTOFF); // R11
	assign pwr_code = (pstate == PS_WORK)  ? saf_pkg::PWR_WORK :                 // R8
	                  (pstate == PS_SLEEP) ? saf_pkg::PWR_SLEEP :
	                  (pstate == PS_SOFTOFF) ? saf_pkg::PWR_SOFTOFF : saf_pkg::PWR_PREBOOT;

	// Override wins; other exits follow the state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pstate <= PS_PREBOOT;
		end else begin
			case (pstate)
				PS_PREBOOT: begin
					if (ovr) pstate <= PS_SOFTOFF;                 // R12
					else if (cpu_rise) pstate <= PS_WORK;          // R12
				end
				PS_WORK: begin
					if (ovr || go_off) pstate <= PS_SOFTOFF;       // R13 R16
					else if (go_sleep) pstate <= PS_SLEEP;         // R13 R14
				end
				PS_SLEEP: begin
					if (ovr) pstate <= PS_SOFTOFF;                 // R15
					else if (wake) pstate <= PS_PREBOOT;           // R15 R11
				end
				PS_SOFTOFF: begin
					if (to_preboot) pstate <= PS_PREBOOT;          // R16 R11
				end
				default: pstate <= PS_PREBOOT;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Events and message start
	// ----------------------------------------------------------------
	assign hb_due   = (pstate == PS_SLEEP) && (hb_cnt >= HB_CYCLES - 32'h1); // R17
	assign tx_start = !tx_busy && (ev_health || ev_sw || ev_other || hb_due); // R18

	// Pending flags; a new event in the capture cycle is kept
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_health <= 1'b0;
			ev_sw     <= 1'b0;
			ev_other  <= 1'b1; // Leaving power loss counts as pre-boot entry
		end else begin
			ev_health <= health_timer_expired | (ev_health & ~tx_start);     // R1
			ev_sw     <= transmit_request_bit | (ev_sw & ~tx_start);         // R2
			ev_other  <= evt_edge | to_preboot | (pstate == PS_SLEEP && wake)
			           | (ev_other & ~tx_start);                             // R4 R11
		end
	end

	// Heartbeat restarts at every message start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hb_cnt <= 32'h00000000;
		end else if (tx_start || pstate != PS_SLEEP) begin
			hb_cnt <= 32'h00000000;                                      // R18
		end else begin
			hb_cnt <= hb_cnt + 32'h00000001;                             // R17
		end
	end

	// Capture of all fields at start, held while shifting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame           <= '0;
			message_counter <= saf_pkg::SEQ_RST;                         // R5
		end else if (tx_start) begin
			frame <= {ev_health | health_timer_expired,                  // R1 R20
			          ev_sw | transmit_request_bit,                      // R2
			          ~sync2[saf_pkg::SY_EVT],                           // R3
			          message_counter, pwr_code,                         // R7 R8
			          user_message_one, user_message_two,                // R9
			          watchdog_state_byte};                              // R10
			message_counter <= message_counter + 4'h1;                   // R5 R6
		end
	end

	// ----------------------------------------------------------------
	// Link acknowledge status
	// ----------------------------------------------------------------
	// Missing acknowledge is recorded; the message is not repeated
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nack <= 1'b0;
		end else begin
			nack <= (tx_done & ~tx_ack)                                  // R19
			      | (nack & ~(wr & sel(paddr, saf_pkg::OFF_STATUS)
			                  & pwdata[saf_pkg::ST_NACK]));
		end
	end

	// ----------------------------------------------------------------
	// Serial link
	// ----------------------------------------------------------------
	// Start one cycle late, once the frame is captured
	logic start_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_q <= 1'b0;
		end else begin
			start_q <= tx_start;
		end
	end

	saf_shifter #(
		.HALF (HALF),
		.NB   (saf_pkg::FRAME_BITS)
	) u_shifter (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (start_q),
		.frame   (frame),
		.scl_in  (sync2[saf_pkg::SY_CLK]),
		.sda_in  (sync2[saf_pkg::SY_DAT]),
		.busy    (),
		.done    (tx_done),
		.ack_ok  (tx_ack),
		.scl_oe  (scl_oe),
		.sda_oe  (sda_oe)
	);

	// Busy covers the capture cycle as well as the shift
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_busy <= 1'b0;
		end else if (tx_start) begin
			tx_busy <= 1'b1;
		end else if (tx_done) begin
			tx_busy <= 1'b0;
		end
	end

	// Open drain: only ever pull low
	assign alert_link_clock_o  = 1'b0;
	assign alert_link_clock_oe = scl_oe;
	assign alert_link_data_o   = 1'b0;
	assign alert_link_data_oe  = sda_oe;

endmodule : saf_framer

// ==== verification/saf_framer_checker.sv ====
// Port assertions for the alert message framer
`timescale 1ns/1ns
module saf_framer_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        health_timer_expired,
	input wire logic        event_input_pin,
	input wire logic        power_button_override,
	input wire logic        wake_event,
	input wire logic        deep_sleep_control_n,
	input wire logic        alert_link_clock_o,
	input wire logic        alert_link_clock_oe,
	input wire logic        alert_link_data_o,
	input wire logic        alert_link_data_oe
);
	// ----------------------------------------------------------------
	// Link framing helpers
	// ----------------------------------------------------------------
	logic       clk_q;  // Previous clock pull
	logic       dat_q;  // Previous data pull
	logic [7:0] pulses; // Clock pulls since start
	wire sleep_wr   = psel && penable && pwrite && paddr == 8'h00 && pwdata[1];
	wire link_start = alert_link_data_oe && !dat_q && !alert_link_clock_oe;
	wire link_stop  = !alert_link_data_oe && dat_q && !alert_link_clock_oe;
	// Clock pulls since start, checked at stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_q <= 1'b0;
			dat_q <= 1'b0;
			pulses <= 8'h00;
		end else begin
			clk_q <= alert_link_clock_oe;
			dat_q <= alert_link_data_oe;
			if (link_start) pulses <= 8'h00;
			else if (alert_link_clock_oe && !clk_q) pulses <= pulses + 8'h01;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_zero_wait: assert property (psel && penable |-> pready) else $error("no ready");
	chk_bad_addr: assert property (psel && penable && paddr > 8'h10 |-> pslverr)
		else $error("no slave error");
	chk_pins_low: assert property (!alert_link_clock_o && !alert_link_data_o)
		else $error("link driven high");
	chk_type_ignored: assert property (sleep_wr && (pwdata[4:2] == 3'h0 || pwdata[4:2] > 3'h5)
		|=> $stable(deep_sleep_control_n)) else $error("bad type acted on");
	chk_sleep_cause: assert property ($fell(deep_sleep_control_n) |->
		$past(sleep_wr) || $past(power_button_override, 3)) else $error("sleep uncaused");
	chk_wake_exit: assert property ($rose(wake_event) && !deep_sleep_control_n
		|-> ##[1:6] deep_sleep_control_n) else $error("no wake exit");
	chk_preboot_msg: assert property ($rose(deep_sleep_control_n) |-> ##[1:1000] link_start)
		else $error("no pre-boot message");
	chk_edge_msg: assert property ($changed(event_input_pin) |-> ##[1:1000] link_start)
		else $error("no pin message");
	chk_timer_msg: assert property (health_timer_expired |-> ##[1:1000] link_start)
		else $error("no timer message");
	chk_frame_len: assert property (link_stop |-> pulses == 8'h23)
		else $error("bad frame length");
	cover property (link_start);
	cover property ($fell(deep_sleep_control_n));
	cover property (psel && penable && pslverr);
endmodule : saf_framer_checker

bind saf_framer saf_framer_checker u_chk (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
	.health_timer_expired, .event_input_pin, .power_button_override, .wake_event,
	.deep_sleep_control_n, .alert_link_clock_o, .alert_link_clock_oe, .alert_link_data_o,
	.alert_link_data_oe);

// ==== verification/saf_alert_partner.sv ====
// Behavioural network controller on the alert link
`timescale 1ns/1ns
module saf_alert_partner (
	input  wire logic   scl,    // Resolved link clock
	input  wire logic   sda,    // Resolved link data
	input  wire logic   ack_en, // Acknowledge messages
	input  wire logic   slow,   // Stretch each low half
	output logic        scl_oe, // Pull clock low
	output logic        sda_oe, // Pull data low
	output logic [32:0] rx,     // Last message bits
	output int          frames  // Completed messages
);
	int nbits = 40; // 40 idle, 34 waiting stop
	bit ack_slot;   // Inside acknowledge slot
	initial begin
		scl_oe = 0;
		sda_oe = 0;
		rx = '0;
		frames = 0;
	end
	// Start: data falls while clock high
	always @(negedge sda) if (scl === 1'b1) nbits = 0;
	// Bits on clock rise, MSB first
	always @(posedge scl) if (nbits < 33) begin
		rx = {rx[31:0], sda};
		nbits++;
	end
	// Ack after last bit; slow mode stretches low
	always @(negedge scl) begin
		if (ack_slot) begin
			sda_oe = 0;
			ack_slot = 0;
			nbits = 34;
		end else if (nbits == 33) begin
			sda_oe = ack_en;
			ack_slot = 1;
		end
		if (slow) begin
			scl_oe = 1;
			#200 scl_oe = 0;
		end
	end
	// Stop: data rises while clock high
	always @(posedge sda) if (scl === 1'b1 && nbits == 34) begin
		frames++;
		nbits = 40;
	end
endmodule : saf_alert_partner

// ==== verification/testbench.sv ====
// Self-checking bench for the alert message framer
`timescale 1ns/1ns
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
	$display("ERROR %0t: got %h expected %h", $time, a, e); end end
module testbench;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = '0, prdata, rd;
	logic        pready, pslverr, err, dsc_n, c_o, c_oe, d_o, d_oe, p_coe, p_doe;
	logic        hte = 0, evt = 1, cpu_n = 0, ovr = 0, wake = 0, ack_en = 1, slow = 0;
	logic [32:0] rx;
	logic [3:0]  seq = 4'h0; // Next expected counter
	logic [23:0] msg = '0;   // Written bytes
	int          frames, seen = 0, miscompares = 0, samples_checked = 0;
	wire scl = !c_oe && !p_coe; // Pull-ups unless pulled low
	wire sda = !d_oe && !p_doe;
	always #5 pclk = ~pclk;
	saf_framer #(.HB_CYCLES(32'h7d0)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .health_timer_expired(hte),
		.event_input_pin(evt), .processor_reset_n(cpu_n), .power_button_override(ovr),
		.wake_event(wake), .deep_sleep_control_n(dsc_n), .alert_link_clock_i(scl),
		.alert_link_clock_o(c_o), .alert_link_clock_oe(c_oe), .alert_link_data_i(sda),
		.alert_link_data_o(d_o), .alert_link_data_oe(d_oe));
	saf_alert_partner u_ctl (.scl, .sda, .ack_en, .slow, .scl_oe(p_coe), .sda_oe(p_doe),
		.rx, .frames);
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task close_out;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out
	// One APB transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (n >= 20) begin miscompares++; close_out(); end
	endtask : apb
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(0, a, '0);
		`CHK(rd, e)
	endtask : rdchk
	// Await next message, check all fields
	task frame(input logic h, s, g, input logic [1:0] p);
		int n;
		n = 0;
		while (frames == seen && n < 9000) begin @(posedge pclk); n++; end
		if (n >= 9000) begin miscompares++; close_out(); end
		seen++;
		repeat (4) @(posedge pclk); // Let busy drop
		`CHK(rx, {h, s, g, seq, p, msg})
		seq++;
	endtask : frame
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1;
		rdchk(8'h04, 32'h0);
		frame(0, 0, 0, 2'h3);
		apb(1, 8'h04, 32'ha5);
		apb(1, 8'h08, 32'h3c);
		apb(1, 8'h0c, 32'h81);
		msg = 24'ha53c81;
		cpu_n <= 1;
		repeat (6) @(posedge pclk);
		rdchk(8'h10, {26'h0, 2'h0, seq});
		apb(1, 8'h00, 32'h1);
		frame(0, 1, 0, 2'h0);
		hte <= 1;
		@(posedge pclk);
		hte <= 0;
		frame(1, 0, 0, 2'h0);
		evt <= 0;
		frame(0, 0, 1, 2'h0);
		evt <= 1;
		frame(0, 0, 0, 2'h0);
		for (int i = 0; i < 12; i++) begin
			apb(1, 8'h00, 32'h1);
			frame(0, 1, 0, 2'h0);
		end
		ack_en <= 0;
		apb(1, 8'h00, 32'h1);
		frame(0, 1, 0, 2'h0);
		rdchk(8'h10, {24'h0, 2'h2, 2'h0, seq});
		apb(1, 8'h10, 32'h80);
		ack_en <= 1;
		apb(1, 8'h00, 32'h2);
		rdchk(8'h10, {26'h0, 2'h0, seq});
		slow <= 1;
		apb(1, 8'h00, 32'h0e);
		rdchk(8'h10, {26'h0, 2'h1, seq});
		`CHK(dsc_n, 1'b0)
		frame(0, 0, 0, 2'h1);
		slow <= 0;
		wake <= 1;
		repeat (8) @(posedge pclk);
		wake <= 0;
		frame(0, 0, 0, 2'h3);
		cpu_n <= 0;
		repeat (4) @(posedge pclk);
		cpu_n <= 1;
		repeat (6) @(posedge pclk);
		apb(1, 8'h00, 32'h16);
		rdchk(8'h10, {26'h0, 2'h2, seq});
		wake <= 1;
		repeat (8) @(posedge pclk);
		wake <= 0;
		frame(0, 0, 0, 2'h3);
		ovr <= 1;
		repeat (6) @(posedge pclk);
		rdchk(8'h10, {26'h0, 2'h2, seq});
		apb(0, 8'h20, '0);
		`CHK(err, 1'b1)
		`CHK(rd, 32'h0)
		close_out();
	end
endmodule : testbench
